/* uedsi_pkg.sv */
// Constants, field layouts and carrier types for the endpoint status and info block.
package uedsi_pkg;

  // ==========================================================================
  // Register byte addresses.
  localparam logic [31:0] IrqMaskAddr   = 32'hfff0606c;
  localparam logic [31:0] FlagClearAddr = 32'hfff06070;
  localparam logic [31:0] FlagsAddr     = 32'hfff06074;
  localparam logic [31:0] PointerAddr   = 32'hfff06078;
  localparam logic [31:0] ByteCountAddr = 32'hfff0607c;
  localparam logic [31:0] DescAddr      = 32'hfff06080;

  // ==========================================================================
  // Field positions and widths.
  localparam int FlagW    = 6;
  localparam int LenW     = 20;
  localparam int HaltBit  = 0;
  localparam int TokenBit = 1;
  localparam int AltBit   = 2;
  localparam int DoneBit  = 3;
  localparam int FaultBit = 4;
  localparam int CfBit    = 5;

  // Writable bits of the descriptor word: type, direction, size, interface, config, number.
  localparam logic [31:0] DescWrMask = 32'h73ff0fff;
  localparam int          AltLsb     = 12;
  localparam logic [31:0] AltMask    = 32'h0000f000;
  localparam int          KindLsb    = 29;
  localparam int          KindW      = 2;
  localparam int          DirBit     = 28;
  localparam int          MpsLsb     = 16;
  localparam int          MpsW       = 10;
  localparam int          IfLsb      = 8;
  localparam int          CfgLsb     = 4;
  localparam int          NumLsb     = 0;
  localparam int          IdW        = 4;

  // ==========================================================================
  // Reset values and transfer kinds.
  localparam logic [31:0] ZeroWord    = 32'h00000000;
  localparam logic [31:0] PointerRst  = 32'h00000000;
  localparam logic [1:0]  KindBulk    = 2'h1;
  localparam logic [1:0]  KindIntr    = 2'h2;
  localparam logic [1:0]  KindIso     = 2'h3;

  // Event strobes from the endpoint engine, one cycle each.
  typedef struct packed {
    logic clearFeature;
    logic busFault;
    logic altSetting;
    logic token;
    logic halt;
  } uedsi_events_t;

  // Descriptor of endpoint C as seen by the engine.
  typedef struct packed {
    logic [1:0] transferKind;
    logic       direction;
    logic [9:0] maxPacket;
    logic [3:0] interfaceNo;
    logic [3:0] configNo;
    logic [3:0] endpointNo;
  } uedsi_desc_t;

endpackage : uedsi_pkg

/* uedsi_top.sv */
// Register logic for endpoint B status and DMA, and the endpoint C descriptor.
//
// Strobed register access was chosen for this implementation.
module uedsi_top
  import uedsi_pkg::*;
(
  // Clock and reset.
  input  wire logic          clock,
  input  wire logic          arst_n,
  // Register port.
  input  wire logic [31:0]   regAddr,
  input  wire logic [31:0]   regWrData,
  input  wire logic          regWrite,
  input  wire logic          regRead,
  output logic      [31:0]   regRdData,
  // Endpoint events from the engine.
  input  wire uedsi_events_t epEvents,
  // DMA byte progress: bytes moved this cycle.
  input  wire logic          dmaBeat,
  input  wire logic [2:0]    dmaBeatBytes,
  // Alternate setting chosen by the host for endpoint C.
  input  wire logic [3:0]    altSettingIn,
  // Outputs toward the engine.
  output logic      [31:0]   dmaPointer,
  output logic      [LenW-1:0] dmaByteCount,
  output logic               dmaBusy,
  output uedsi_desc_t        epcDesc,
  // Interrupt.
  output logic               epIrq
);

  // ==========================================================================
  // Storage.
  logic [FlagW-1:0] flags_q;
  logic [FlagW-1:0] mask_q;
  logic [31:0]      pointer_q;
  logic [LenW-1:0]  count_q;
  logic [LenW-1:0]  moved_q;
  logic             busy_q;
  logic [31:0]      desc_q;
  logic [31:0]      rdData_q;
  logic [FlagW-1:0] setVec;
  logic [FlagW-1:0] clrVec;
  logic             doneEvt;
  logic [LenW-1:0]  movedNext;

  // Address match is shared by every decode.
  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    return a == r;
  endfunction : hit

  // ==========================================================================
  // DMA byte counting.
  // byte count done
  assign movedNext = moved_q + LenW'(dmaBeatBytes);
  assign doneEvt   = busy_q && dmaBeat && (movedNext >= count_q);

  // A write to the length register arms a new transfer; zero length never arms.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_q  <= 1'b0;
      moved_q <= '0;
    end else if (regWrite && hit(regAddr, ByteCountAddr)) begin
      busy_q  <= regWrData[LenW-1:0] != '0;
      moved_q <= '0;
    end else if (doneEvt) begin
      busy_q  <= 1'b0;
      moved_q <= movedNext;
    end else if (busy_q && dmaBeat) begin
      moved_q <= movedNext;
    end
  end

  // ==========================================================================
  // Event flags.
  always_comb begin
    setVec = '0;
    setVec[HaltBit]  = epEvents.halt;
    setVec[TokenBit] = epEvents.token;
    setVec[AltBit]   = epEvents.altSetting;
    setVec[DoneBit]  = doneEvt;
    setVec[FaultBit] = epEvents.busFault;
    setVec[CfBit]    = epEvents.clearFeature;
  end

  assign clrVec = (regWrite && hit(regAddr, FlagClearAddr)) ? regWrData[FlagW-1:0] : '0;

  // A read of the flags also clears them; a new event in that cycle still wins.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= '0;
    end else if (regRead && hit(regAddr, FlagsAddr)) begin
      flags_q <= setVec;
    end else begin
      flags_q <= (flags_q & ~clrVec) | setVec;
    end
  end

  // ==========================================================================
  // Writable registers.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mask_q    <= '0;
      pointer_q <= PointerRst;
      count_q   <= '0;
    end else if (regWrite) begin
      if (hit(regAddr, IrqMaskAddr)) begin
        mask_q <= regWrData[FlagW-1:0];
      end else if (hit(regAddr, PointerAddr)) begin
        pointer_q <= regWrData;
      end else if (hit(regAddr, ByteCountAddr)) begin
        count_q <= regWrData[LenW-1:0];
      end
    end
  end

  // Descriptor: software fields from writes, alternate setting from the host.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      desc_q <= ZeroWord;
    end else begin
      if (regWrite && hit(regAddr, DescAddr)) begin
        desc_q[31:AltLsb+4] <= regWrData[31:AltLsb+4] & DescWrMask[31:AltLsb+4];
        desc_q[AltLsb-1:0]  <= regWrData[AltLsb-1:0];
      end
      desc_q[AltLsb+3:AltLsb] <= altSettingIn;
    end
  end

  // ==========================================================================
  // Read data, one cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdData_q <= ZeroWord;
    end else if (regRead) begin
      if (hit(regAddr, FlagsAddr)) begin
        rdData_q <= {{(32-FlagW){1'b0}}, flags_q};
      end else if (hit(regAddr, IrqMaskAddr)) begin
        rdData_q <= {{(32-FlagW){1'b0}}, mask_q};
      end else if (hit(regAddr, PointerAddr)) begin
        rdData_q <= pointer_q;
      end else if (hit(regAddr, ByteCountAddr)) begin
        rdData_q <= {{(32-LenW){1'b0}}, count_q};
      end else if (hit(regAddr, DescAddr)) begin
        rdData_q <= desc_q;
      end else begin
        rdData_q <= ZeroWord;
      end
    end else begin
      rdData_q <= ZeroWord;
    end
  end

  // ==========================================================================
  // Outputs.
  assign regRdData    = rdData_q;
  assign dmaPointer   = pointer_q;
  assign dmaByteCount = count_q;
  assign dmaBusy      = busy_q;
  assign epcDesc.transferKind = desc_q[KindLsb +: KindW];
  assign epcDesc.direction    = desc_q[DirBit];
  assign epcDesc.maxPacket    = desc_q[MpsLsb +: MpsW];
  assign epcDesc.interfaceNo  = desc_q[IfLsb +: IdW];
  assign epcDesc.configNo     = desc_q[CfgLsb +: IdW];
  assign epcDesc.endpointNo   = desc_q[NumLsb +: IdW];
  assign epIrq = |(flags_q & mask_q);

  // ==========================================================================
  // Checks.
  flags_reserved_a: assert property (@(posedge clock) disable iff (!arst_n)
    $past(regRead) && $past(regAddr) == FlagsAddr |-> regRdData[31:FlagW] == '0)
    else $error("Reserved flag bits read nonzero.");
  cf_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    epEvents.clearFeature |=> flags_q[CfBit])
    else $error("Clear feature flag not set.");
  fault_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    epEvents.busFault |=> flags_q[FaultBit])
    else $error("Bus fault flag not set.");
  done_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    doneEvt && !(regWrite && regAddr == ByteCountAddr) |=> flags_q[DoneBit] && !busy_q)
    else $error("Done flag not set.");
  alt_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    epEvents.altSetting |=> flags_q[AltBit])
    else $error("Alt flag not set.");
  token_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    epEvents.token |=> flags_q[TokenBit])
    else $error("Token flag not set.");
  halt_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    epEvents.halt |=> flags_q[HaltBit])
    else $error("Halt flag not set.");
  pointer_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == PointerAddr |=> dmaPointer == $past(regWrData))
    else $error("Pointer not written.");
  count_write_a: assert property (@(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == ByteCountAddr |=> dmaByteCount == $past(regWrData[LenW-1:0]))
    else $error("Byte count not written.");
  alt_readonly_a: assert property (@(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == DescAddr |=> desc_q[AltLsb +: 4] == $past(altSettingIn))
    else $error("Alt setting not from host.");
  clear_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == FlagClearAddr && regWrData[TokenBit] && !epEvents.token
      |=> !flags_q[TokenBit])
    else $error("Flag not cleared.");
  irq_mask_a: assert property (@(posedge clock) disable iff (!arst_n)
    epEvents.halt && mask_q[HaltBit] && !regWrite |=> epIrq)
    else $error("Interrupt disagrees with mask.");

  // ==========================================================================
  // Further checks. These watch holds, read paths and the transfer counter in
  // every cycle, because the bench reaches each of them from one side only.

  rd_idle_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !regRead |=> regRdData == ZeroWord)
    else $error("Read data not zero outside a read.");

  flags_read_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regRead && regAddr == FlagsAddr |=> regRdData[FlagW-1:0] == $past(flags_q))
    else $error("Flags read back wrong.");

  read_clears_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regRead && regAddr == FlagsAddr && epEvents == '0 && !doneEvt |=> flags_q == '0)
    else $error("Flags not cleared by a read.");

  halt_wins_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == FlagClearAddr && regWrData[HaltBit] && epEvents.halt |=> flags_q[HaltBit])
    else $error("Halt event lost to a clear.");

  token_wins_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regRead && regAddr == FlagsAddr && epEvents.token |=> flags_q[TokenBit])
    else $error("Token event lost to a read.");

  done_only_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !doneEvt && !flags_q[DoneBit] |=> !flags_q[DoneBit])
    else $error("Done flag raised without completion.");

  clear_all_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == FlagClearAddr && epEvents == '0 && !doneEvt
      |=> (flags_q & $past(regWrData[FlagW-1:0])) == '0)
    else $error("Cleared flag still set.");

  clear_reads_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regRead && regAddr == FlagClearAddr |=> regRdData == ZeroWord)
    else $error("Clear register read nonzero.");

  ptr_hold_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !(regWrite && regAddr == PointerAddr) |=> $stable(dmaPointer))
    else $error("Pointer changed without a write.");

  ptr_read_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regRead && regAddr == PointerAddr |=> regRdData == $past(dmaPointer))
    else $error("Pointer read back wrong.");

  count_hold_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !(regWrite && regAddr == ByteCountAddr) |=> $stable(dmaByteCount))
    else $error("Byte count changed without a write.");

  count_read_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regRead && regAddr == ByteCountAddr |=> regRdData[31:LenW] == '0 && regRdData[LenW-1:0] == $past(dmaByteCount))
    else $error("Byte count read back wrong.");

  start_busy_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == ByteCountAddr && regWrData[LenW-1:0] != '0 |=> dmaBusy)
    else $error("Transfer not started.");

  zero_len_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == ByteCountAddr && regWrData[LenW-1:0] == '0 |=> !dmaBusy)
    else $error("Zero length started a transfer.");

  busy_bound_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    busy_q |-> moved_q < count_q)
    else $error("Transfer still busy after its length.");

  idle_stays_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !busy_q && !(regWrite && regAddr == ByteCountAddr) |=> !busy_q)
    else $error("Transfer started without a write.");

  mask_write_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == IrqMaskAddr |=> mask_q == $past(regWrData[FlagW-1:0]))
    else $error("Mask not written.");

  mask_read_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regRead && regAddr == IrqMaskAddr |=> regRdData[31:FlagW] == '0 && regRdData[FlagW-1:0] == $past(mask_q))
    else $error("Mask read back wrong.");

  desc_reserved_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    (desc_q & ~(DescWrMask | AltMask)) == ZeroWord)
    else $error("Reserved descriptor bits set.");

  kind_write_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == DescAddr |=> epcDesc.transferKind == $past(regWrData[KindLsb +: KindW]))
    else $error("Transfer kind not written.");

  dir_write_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == DescAddr |=> epcDesc.direction == $past(regWrData[DirBit]))
    else $error("Direction not written.");

  mps_write_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == DescAddr |=> epcDesc.maxPacket == $past(regWrData[MpsLsb +: MpsW]))
    else $error("Max packet not written.");

  ids_write_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regWrite && regAddr == DescAddr |=> epcDesc.endpointNo == $past(regWrData[NumLsb +: IdW])
      && epcDesc.configNo == $past(regWrData[CfgLsb +: IdW]) && epcDesc.interfaceNo == $past(regWrData[IfLsb +: IdW]))
    else $error("Descriptor ids not written.");

  desc_hold_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    !(regWrite && regAddr == DescAddr) |=> $stable(epcDesc))
    else $error("Descriptor changed without a write.");

  desc_read_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regRead && regAddr == DescAddr |=> regRdData == $past(desc_q))
    else $error("Descriptor read back wrong.");

  alt_read_a: assert property (
    @(posedge clock) disable iff (!arst_n)
    regRead && regAddr == DescAddr |=> regRdData[AltLsb +: 4] == $past(altSettingIn, 2))
    else $error("Alt setting read back wrong.");

endmodule : uedsi_top

/* uedsi_engine_model.sv */
// Behavioural endpoint engine that moves DMA bytes while a transfer is armed.
module uedsi_engine_model (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Transfer control.
  input  wire logic       dmaBusy,
  input  wire logic       slowMode,
  // Byte progress.
  output logic            dmaBeat,
  output logic [2:0]      dmaBeatBytes
);
  timeunit 1ns;
  timeprecision 1ps;

  logic phase_q;

  // ==========================================================================
  // Pacing: slow mode stalls every other cycle, so completion must follow real byte counts.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  assign dmaBeat      = dmaBusy & (~slowMode | phase_q);
  // The byte count wanders between beats because nothing moved then.
  assign dmaBeatBytes = dmaBeat ? 3'h4 : {phase_q, 2'h3};
endmodule : uedsi_engine_model

/* test_usb_endpoint_dma_status_and_info.sv */
// Self-checking bench for the endpoint status, DMA and descriptor registers.
module test_usb_endpoint_dma_status_and_info;
  import uedsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clock, arst_n, regWrite, regRead, dmaBeat, dmaBusy, epIrq, slowMode;
  logic [31:0]     regAddr, regWrData, regRdData, dmaPointer, rdv;
  logic [2:0]      dmaBeatBytes;
  logic [3:0]      altSettingIn;
  logic [LenW-1:0] dmaByteCount;
  uedsi_events_t   epEvents;
  uedsi_desc_t     epcDesc;
  int              n_fail, cmp_count, cycles;
  int              beats = 0, b0;
  int              flagPos [5] = '{0, 1, 2, 4, 5};

  uedsi_top uut (.clock(clock), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .epEvents(epEvents),
    .dmaBeat(dmaBeat), .dmaBeatBytes(dmaBeatBytes), .altSettingIn(altSettingIn),
    .dmaPointer(dmaPointer), .dmaByteCount(dmaByteCount), .dmaBusy(dmaBusy),
    .epcDesc(epcDesc), .epIrq(epIrq));

  uedsi_engine_model engine (.clock(clock), .arst_n(arst_n), .dmaBusy(dmaBusy),
    .slowMode(slowMode), .dmaBeat(dmaBeat), .dmaBeatBytes(dmaBeatBytes));

  // ==========================================================================
  // Clock, watchdog and shared tasks.
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // The whole run needs well under a thousand cycles; the ceiling catches a stuck wait.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail++;
      test_done();
    end
  end

  // Beats the design accepts, counted on the same edges at which it samples them.
  always @(posedge clock) if (dmaBusy && dmaBeat) beats <= beats + 1;

  task automatic test_done();
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle write strobe; its effect is visible just after the closing edge.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite  <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask : rd

  task automatic pulse(input logic [4:0] e);
    @(posedge clock);
    epEvents <= uedsi_events_t'(e);
    @(posedge clock);
    epEvents <= '0;
    #1;
  endtask : pulse

  // ==========================================================================
  // Main sequence.
  initial begin
    arst_n = 1'b0; regWrite = 1'b0; regRead = 1'b0; regAddr = '0; regWrData = '0;
    epEvents = '0; altSettingIn = 4'ha; slowMode = 1'b0; n_fail = 0; cmp_count = 0; cycles = 0;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    rd(FlagsAddr, rdv); chk(rdv, ZeroWord);
    rd(ByteCountAddr, rdv); chk(rdv, ZeroWord);
    rd(DescAddr, rdv); chk(rdv, 32'h0000a000);
    rd(32'hfff06090, rdv); chk(rdv, ZeroWord);
    wr(FlagsAddr, 32'hffffffff); rd(FlagsAddr, rdv); chk(rdv, ZeroWord);
    wr(PointerAddr, 32'hdeadbeef); chk(dmaPointer, 32'hdeadbeef);
    rd(PointerAddr, rdv); chk(rdv, 32'hdeadbeef);
    // Every event lands on its own flag, and a read empties the register.
    for (int j = 0; j < 5; j++) begin
      pulse(5'h01 << j); chk({31'h0, epIrq}, 32'h0);
      rd(FlagsAddr, rdv); chk(rdv, 32'h1 << flagPos[j]);
      rd(FlagsAddr, rdv); chk(rdv, ZeroWord);
    end
    wr(IrqMaskAddr, 32'h1);
    rd(IrqMaskAddr, rdv); chk(rdv, 32'h1);
    rd(FlagClearAddr, rdv); chk(rdv, ZeroWord);
    pulse(5'h02); chk({31'h0, epIrq}, 32'h0);
    pulse(5'h01); chk({31'h0, epIrq}, 32'h1);
    wr(FlagClearAddr, 32'h1); chk({31'h0, epIrq}, 32'h0);
    rd(FlagsAddr, rdv); chk(rdv, 32'h2);
    // An event in the cycle of a clear or a read must survive it.
    fork pulse(5'h01); wr(FlagClearAddr, 32'h1); join
    chk({31'h0, epIrq}, 32'h1);
    fork pulse(5'h02); rd(FlagsAddr, rdv); join
    chk(rdv, 32'h1);
    rd(FlagsAddr, rdv); chk(rdv, 32'h2);
    // Transfers at full pace and with the engine stalling.
    wr(IrqMaskAddr, 32'h8);
    for (int s = 0; s < 2; s++) begin
      slowMode <= s[0];
      b0 = beats;
      wr(ByteCountAddr, 32'hfff00000 | (12 + 4 * s)); chk({31'h0, dmaBusy}, 32'h1);
      chk({12'h0, dmaByteCount}, 32'(12 + 4 * s));
      @(posedge clock); #1 chk({31'h0, epIrq}, 32'h0);
      rd(ByteCountAddr, rdv); chk(rdv, 32'(12 + 4 * s));
      for (int k = 0; k < 40 && dmaBusy; k++) begin
        @(posedge clock);
        #1;
      end
      #1 chk({30'h0, epIrq, dmaBusy}, 32'h2);
      chk(32'(beats - b0), 32'(3 + s));
      rd(FlagsAddr, rdv); chk(rdv, 32'h8);
    end
    wr(ByteCountAddr, ZeroWord); chk({31'h0, dmaBusy}, 32'h0);
    // Each transfer kind, with reserved and read-only bits written as ones.
    for (int k = 1; k < 4; k++) begin
      wr(DescAddr, {1'b1, k[1:0], 29'h1fffffff});
      chk({7'h0, epcDesc}, {7'h0, k[1:0], 1'b1, 10'h3ff, 12'hfff});
      rd(DescAddr, rdv); chk(rdv, {1'b0, k[1:0], 3'h4, 10'h3ff, 4'ha, 12'hfff});
    end
    altSettingIn <= 4'h5;
    wr(DescAddr, ZeroWord); rd(DescAddr, rdv); chk(rdv, 32'h00005000);
    // A reset in mid-run empties flags, length and ids while the host's alt setting flows on.
    pulse(5'h01); wr(DescAddr, 32'h00000123); wr(ByteCountAddr, 32'h40);
    @(posedge clock);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    #1 chk({30'h0, epIrq, dmaBusy}, 32'h0);
    rd(FlagsAddr, rdv); chk(rdv, ZeroWord);
    rd(ByteCountAddr, rdv); chk(rdv, ZeroWord);
    chk(dmaPointer, PointerRst);
    rd(DescAddr, rdv); chk(rdv, 32'h00005000);
    test_done();
  end
endmodule : test_usb_endpoint_dma_status_and_info
